// ### rtl/bridge_pkg.sv
// Constants shared by the host I/O to STD Bus bridge
// What this block does
// - Forward only host I/O cycles, never memory
// - Static select between 8-bit and 10-bit decode
// - 10-bit mode drives address bits 0..9
// - 8-bit mode forwards only 100h to 1FFh
// - Host read/write strobes make STD request strobes
// - Request held inactive during host DMA
// - No added waits; pass card wait to ready
// - One byte per cycle, bidirectional data path
// - Five host interrupt outputs, lines 3..7
// - Each output picks one of four STD requests
// - No cascade acknowledge address is generated
// - STD system reset follows host reset
package bridge_pkg;
    localparam int ADDR_W = 10;
    localparam int DATA_W = 8;
    localparam int IRQ_N = 5;
    localparam int SRC_SEL_W = 2;
    // Window for 8-bit decode: host bits 9:8 must read 01
    localparam logic [1:0] WIN8_HI = 2'h1;
    // Interrupt source encodings
    localparam logic [1:0] SRC_INTRQ = 2'h0;
    localparam logic [1:0] SRC_INTRQ1 = 2'h1;
    localparam logic [1:0] SRC_INTRQ2 = 2'h2;
    localparam logic [1:0] SRC_NMIRQ = 2'h3;
    // Cycle tracker states, each busy state one bit away from idle
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_READ = 2'b01,
        ST_WRITE = 2'b10
    } cycle_state_t;
endpackage

// ### rtl/host_std_bridge.sv
// Host expansion-bus I/O cycles to STD Bus bridge top level
module host_std_bridge (
    input wire logic i_core_clk,
    input wire logic i_reset,
    // Host side
    input wire logic [bridge_pkg::ADDR_W-1:0] i_host_addr,
    input wire logic i_host_ior_n,
    input wire logic i_host_iow_n,
    input wire logic i_host_memr_n,
    input wire logic i_host_memw_n,
    input wire logic i_host_aen,
    input wire logic [bridge_pkg::DATA_W-1:0] i_host_data,
    output logic [bridge_pkg::DATA_W-1:0] o_host_data,
    output logic o_host_data_oe,
    output logic o_host_chrdy,
    output logic [bridge_pkg::IRQ_N-1:0] o_host_irq,
    // Static configuration
    input wire logic i_address_width_select,
    input wire logic [2*bridge_pkg::IRQ_N-1:0] i_irq_sel,
    // STD Bus side
    output logic [bridge_pkg::ADDR_W-1:0] o_std_addr,
    output logic o_std_iorq_n,
    output logic o_std_rd_n,
    output logic o_std_wr_n,
    output logic [bridge_pkg::DATA_W-1:0] o_std_data,
    output logic o_std_data_oe,
    input wire logic [bridge_pkg::DATA_W-1:0] i_std_data,
    input wire logic i_std_wait_n,
    input wire logic [3:0] i_std_req_n,
    output logic o_std_sysreset_n
);
    // Synchronised host strobes (first stage read only by second)
    logic [3:0] strb_s1;
    logic [3:0] strb_s2;
    // Synchronised card wait request, low asks for a wait
    logic wait_s1;
    logic wait_s2;
    // Synchronised decode width select
    logic cfg_s1;
    logic cfg_s2;
    // Synchronised host DMA flag
    logic dma_s1;
    logic dma_s2;
    // Synchronised host address; it is stable while a strobe is low, so it
    // settles no later than the strobes that qualify it
    logic [bridge_pkg::ADDR_W-1:0] addr_s1;
    logic [bridge_pkg::ADDR_W-1:0] addr_s2;
    // First stage of the host write byte; the STD data register is the second
    logic [bridge_pkg::DATA_W-1:0] hdata_s1;
    // First stage of the card read byte; the host data register is the second
    logic [bridge_pkg::DATA_W-1:0] sdata_s1;
    // Synchronised interrupt source selects
    logic [2*bridge_pkg::IRQ_N-1:0] sel_s1;
    logic [2*bridge_pkg::IRQ_N-1:0] sel_s2;
    // Cycle tracker state
    bridge_pkg::cycle_state_t state;
    bridge_pkg::cycle_state_t next_state;

    // Decoded strobe levels, active high
    wire ior = ~strb_s2[0];
    wire iow = ~strb_s2[1];
    wire mem = ~strb_s2[2] | ~strb_s2[3]; // Memory cycles never forwarded
    // Address window check on the synchronised address
    wire in_win8 = (addr_s2[9:8] == bridge_pkg::WIN8_HI);
    wire in_range = cfg_s2 ? 1'b1 : in_win8;
    // Accepted I/O cycle, blocked under DMA and memory cycles
    wire go = in_range & ~dma_s2 & ~mem;
    // Both strobes low at once is refused
    wire rd_go = go & ior & ~iow;
    wire wr_go = go & iow & ~ior;
    // Address as placed on the STD Bus: upper lines zero in 8-bit mode
    wire [bridge_pkg::ADDR_W-1:0] std_addr_sel = cfg_s2 ? addr_s2 : {2'h0, addr_s2[7:0]};
    // Data-path enables follow the tracked cycle, so they match the strobes
    wire next_host_oe = (next_state == bridge_pkg::ST_READ);
    wire next_std_oe = (next_state == bridge_pkg::ST_WRITE);

    // Synchronisers for the single-bit control pins
    always_ff @(posedge i_core_clk or posedge i_reset) begin
        if (i_reset) begin
            strb_s1 <= 4'hF;
            strb_s2 <= 4'hF;
            wait_s1 <= 1'b1;
            wait_s2 <= 1'b1;
            cfg_s1 <= 1'b0;
            cfg_s2 <= 1'b0;
            dma_s1 <= 1'b0;
            dma_s2 <= 1'b0;
        end else begin
            strb_s1 <= {i_host_memw_n, i_host_memr_n, i_host_iow_n, i_host_ior_n};
            strb_s2 <= strb_s1;
            wait_s1 <= i_std_wait_n;
            wait_s2 <= wait_s1;
            cfg_s1 <= i_address_width_select;
            cfg_s2 <= cfg_s1;
            dma_s1 <= i_host_aen;
            dma_s2 <= dma_s1;
        end
    end

    // Synchronisers for the address, data and select buses
    always_ff @(posedge i_core_clk or posedge i_reset) begin
        if (i_reset) begin
            addr_s1 <= 10'h000;
            addr_s2 <= 10'h000;
            hdata_s1 <= 8'h00;
            sdata_s1 <= 8'h00;
            sel_s1 <= 10'h000;
            sel_s2 <= 10'h000;
        end else begin
            addr_s1 <= i_host_addr;
            addr_s2 <= addr_s1;
            hdata_s1 <= i_host_data;
            sdata_s1 <= i_std_data;
            sel_s1 <= i_irq_sel;
            sel_s2 <= sel_s1;
        end
    end

    // Cycle tracker: idle, read or write
    always_comb begin
        case (state)
            bridge_pkg::ST_IDLE: begin
                if (rd_go) begin
                    next_state = bridge_pkg::ST_READ;
                end else if (wr_go) begin
                    next_state = bridge_pkg::ST_WRITE;
                end else begin
                    next_state = bridge_pkg::ST_IDLE;
                end
            end
            bridge_pkg::ST_READ: begin
                next_state = rd_go ? bridge_pkg::ST_READ : bridge_pkg::ST_IDLE;
            end
            bridge_pkg::ST_WRITE: begin
                next_state = wr_go ? bridge_pkg::ST_WRITE : bridge_pkg::ST_IDLE;
            end
            default: begin
                next_state = bridge_pkg::ST_IDLE;
            end
        endcase
    end

    // State register and STD strobes, registered, no added waits
    always_ff @(posedge i_core_clk or posedge i_reset) begin
        if (i_reset) begin
            state <= bridge_pkg::ST_IDLE;
            o_std_iorq_n <= 1'b1;
            o_std_rd_n <= 1'b1;
            o_std_wr_n <= 1'b1;
        end else begin
            state <= next_state;
            o_std_iorq_n <= (next_state == bridge_pkg::ST_IDLE);
            o_std_rd_n <= (next_state != bridge_pkg::ST_READ);
            o_std_wr_n <= (next_state != bridge_pkg::ST_WRITE);
        end
    end

    // Address and data path, one byte per cycle
    always_ff @(posedge i_core_clk or posedge i_reset) begin
        if (i_reset) begin
            o_std_addr <= 10'h000;
            o_std_data <= 8'h00;
            o_std_data_oe <= 1'b0;
            o_host_data <= 8'h00;
            o_host_data_oe <= 1'b0;
        end else begin
            // Full ten lines in 10-bit mode; A8/A9 carry zero otherwise
            if (rd_go | wr_go) begin
                o_std_addr <= std_addr_sel;
            end
            // Second stage of the byte synchronisers
            o_std_data <= hdata_s1;
            o_std_data_oe <= next_std_oe;
            o_host_data <= sdata_s1;
            o_host_data_oe <= next_host_oe;
        end
    end

    // Synchronised card wait drives host channel ready, registered, outside idle
    always_ff @(posedge i_core_clk or posedge i_reset) begin
        if (i_reset) begin
            o_host_chrdy <= 1'b1;
        end else begin
            o_host_chrdy <= wait_s2 | (state == bridge_pkg::ST_IDLE);
        end
    end

    // STD system reset follows the host reset level
    assign o_std_sysreset_n = ~i_reset;

    // Interrupt routing, one slice per host line 3..7
    genvar g;
    generate
        for (g = 0; g < bridge_pkg::IRQ_N; g++) begin : g_irq
            irq_route u_route (
                .i_core_clk(i_core_clk),
                .i_reset(i_reset),
                .i_std_req_n(i_std_req_n),
                .i_sel(sel_s2[2*g +: 2]),
                .o_irq(o_host_irq[g])
            );
        end
    endgenerate
    // Upper STD address lines only ever carry host address bits or zero, so no
    // cascade acknowledge code is ever placed on them

    // Assertions
    // Memory strobes never reach the STD Bus
    property p_no_mem;
        @(posedge i_core_clk) disable iff (i_reset) mem |=> o_std_iorq_n;
    endproperty
    a_no_mem: assert property (p_no_mem) else $error("Memory cycle reached STD bus");

    // Host DMA holds the request strobe inactive
    property p_dma_block;
        @(posedge i_core_clk) disable iff (i_reset) dma_s2 |=> o_std_iorq_n;
    endproperty
    a_dma_block: assert property (p_dma_block) else $error("Request during DMA");

    // Out-of-window addresses leave the STD Bus idle in 8-bit mode
    property p_win8;
        @(posedge i_core_clk) disable iff (i_reset)
            (!cfg_s2 && addr_s2[9:8] != bridge_pkg::WIN8_HI) |=> o_std_iorq_n;
    endproperty
    a_win8: assert property (p_win8) else $error("Out of window cycle forwarded");

    // All ten lines pass through in 10-bit mode
    property p_addr10;
        @(posedge i_core_clk) disable iff (i_reset)
            (cfg_s2 && (rd_go || wr_go)) |=> o_std_addr == $past(addr_s2);
    endproperty
    a_addr10: assert property (p_addr10) else $error("Address not passed");

    // Upper lines stay zero on cycles decoded in 8-bit mode
    property p_no_cascade;
        @(posedge i_core_clk) disable iff (i_reset)
            (!o_std_iorq_n && !$past(cfg_s2)) |-> o_std_addr[9:8] == 2'h0;
    endproperty
    a_no_cascade: assert property (p_no_cascade) else $error("Upper lines set");

    // Host read gives request and read strobes only
    property p_rd;
        @(posedge i_core_clk) disable iff (i_reset)
            rd_go |=> (!o_std_iorq_n && !o_std_rd_n && o_std_wr_n);
    endproperty
    a_rd: assert property (p_rd) else $error("Read strobes wrong");

    // Host write gives request and write strobes only
    property p_wr;
        @(posedge i_core_clk) disable iff (i_reset)
            wr_go |=> (!o_std_iorq_n && !o_std_wr_n && o_std_rd_n);
    endproperty
    a_wr: assert property (p_wr) else $error("Write strobes wrong");

    // Host data is driven only inside a forwarded read
    property p_rd_data;
        @(posedge i_core_clk) disable iff (i_reset)
            o_host_data_oe |-> (!o_std_rd_n && $past(rd_go));
    endproperty
    a_rd_data: assert property (p_rd_data) else $error("Host data driven off read");

    // A card wait during a cycle pulls channel ready low
    property p_wait;
        @(posedge i_core_clk) disable iff (i_reset)
            (!wait_s2 && state != bridge_pkg::ST_IDLE) |=> !o_host_chrdy;
    endproperty
    a_wait: assert property (p_wait) else $error("Wait not passed");

    // Written byte is the host byte two edges earlier
    property p_wr_data;
        @(posedge i_core_clk) disable iff (i_reset)
            o_std_data_oe |-> (o_std_data == $past(i_host_data, 2));
    endproperty
    a_wr_data: assert property (p_wr_data) else $error("Write byte wrong");

    // Without a card wait the bridge never holds the host
    property p_no_added_wait;
        @(posedge i_core_clk) disable iff (i_reset) wait_s2 |=> o_host_chrdy;
    endproperty
    a_no_added_wait: assert property (p_no_added_wait) else $error("Wait added");

    // Clashing read and write strobes are refused
    property p_both_refused;
        @(posedge i_core_clk) disable iff (i_reset) (ior && iow) |=> o_std_iorq_n;
    endproperty
    a_both_refused: assert property (p_both_refused) else $error("Clash forwarded");

    // The data path drives one direction at a time
    property p_one_direction;
        @(posedge i_core_clk) disable iff (i_reset) !(o_host_data_oe && o_std_data_oe);
    endproperty
    a_one_direction: assert property (p_one_direction) else $error("Both enables on");

    // Main scenarios: read, write, card wait, DMA block, memory block
    c_read: cover property (@(posedge i_core_clk) disable iff (i_reset) rd_go ##1 !rd_go);
    c_write: cover property (@(posedge i_core_clk) disable iff (i_reset) wr_go ##1 !wr_go);
    c_wait: cover property (@(posedge i_core_clk) disable iff (i_reset) !o_host_chrdy);
    c_dma: cover property (@(posedge i_core_clk) disable iff (i_reset) dma_s2 && ior);
    c_mem: cover property (@(posedge i_core_clk) disable iff (i_reset) mem && iow);
endmodule // host_std_bridge

// ### rtl/irq_route.sv
// One interrupt routing slice: picks one active-low STD request
module irq_route (
    input wire logic i_core_clk,
    input wire logic i_reset,
    input wire logic [3:0] i_std_req_n,
    input wire logic [1:0] i_sel,
    output logic o_irq
);
    logic [3:0] sync1; // First stage, read only by second
    logic [3:0] sync2; // Second stage
    wire [3:0] active = ~sync2; // Requests are active low
    wire picked = active[i_sel]; // Source selection

    // Two-stage synchroniser on the card requests
    always_ff @(posedge i_core_clk or posedge i_reset) begin
        if (i_reset) begin
            sync1 <= 4'hF;
            sync2 <= 4'hF;
        end else begin
            sync1 <= i_std_req_n;
            sync2 <= sync1;
        end
    end

    // Registered, active-high host interrupt level
    always_ff @(posedge i_core_clk or posedge i_reset) begin
        if (i_reset) begin
            o_irq <= 1'b0;
        end else begin
            o_irq <= picked;
        end
    end
endmodule // irq_route

// ### sim/host_std_bridge_bench.sv
// Self-checking bench for the host I/O to STD Bus bridge
module host_std_bridge_bench;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic [9:0] addr; logic rd; logic wide; logic fwd;} row_t;
    logic i_core_clk = 1'b0;
    logic i_reset = 1'b1;
    logic [9:0] i_host_addr = 10'h000;
    logic i_host_ior_n = 1'b1;
    logic i_host_iow_n = 1'b1;
    logic i_host_memr_n = 1'b1;
    logic i_host_memw_n = 1'b1;
    logic i_host_aen = 1'b0;
    logic [7:0] i_host_data = 8'h00;
    logic i_address_width_select = 1'b1;
    logic [9:0] i_irq_sel = 10'h000;
    logic [3:0] i_std_req_n = 4'hF;
    logic slow = 1'b0;
    logic [7:0] std_data, o_host_data, o_std_data;
    logic std_wait_n, o_host_data_oe, o_host_chrdy, o_std_iorq_n, o_std_rd_n;
    logic o_std_wr_n, o_std_data_oe, o_std_sysreset_n;
    logic [4:0] o_host_irq;
    logic [9:0] o_std_addr;
    int errors = 0;
    int total_checks = 0;
    int cycles = 0;
    // Ordinary cycles: address, read, 10-bit mode, forwarded
    row_t rows [8] = '{'{10'h000, 1'b1, 1'b1, 1'b1}, '{10'h3FF, 1'b0, 1'b1, 1'b1},
        '{10'h2A5, 1'b1, 1'b1, 1'b1}, '{10'h100, 1'b1, 1'b0, 1'b1},
        '{10'h1FF, 1'b0, 1'b0, 1'b1}, '{10'h0FF, 1'b1, 1'b0, 1'b0},
        '{10'h200, 1'b0, 1'b0, 1'b0}, '{10'h3C3, 1'b1, 1'b0, 1'b0}};
    // 100 MHz clock
    always #5 i_core_clk = ~i_core_clk;
    host_std_bridge DUT (.i_core_clk(i_core_clk), .i_reset(i_reset),
        .i_host_addr(i_host_addr), .i_host_ior_n(i_host_ior_n), .i_host_iow_n(i_host_iow_n),
        .i_host_memr_n(i_host_memr_n), .i_host_memw_n(i_host_memw_n), .i_host_aen(i_host_aen),
        .i_host_data(i_host_data), .o_host_data(o_host_data), .o_host_data_oe(o_host_data_oe),
        .o_host_chrdy(o_host_chrdy), .o_host_irq(o_host_irq),
        .i_address_width_select(i_address_width_select), .i_irq_sel(i_irq_sel),
        .o_std_addr(o_std_addr), .o_std_iorq_n(o_std_iorq_n), .o_std_rd_n(o_std_rd_n),
        .o_std_wr_n(o_std_wr_n), .o_std_data(o_std_data), .o_std_data_oe(o_std_data_oe),
        .i_std_data(std_data), .i_std_wait_n(std_wait_n), .i_std_req_n(i_std_req_n),
        .o_std_sysreset_n(o_std_sysreset_n));
    std_card_model card (.i_core_clk(i_core_clk), .i_addr(o_std_addr),
        .i_iorq_n(o_std_iorq_n), .i_rd_n(o_std_rd_n), .i_slow(slow),
        .o_data(std_data), .o_wait_n(std_wait_n));
    // Prints counts and verdict, then stops
    task automatic finish_test();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // Compares one result
    task automatic chk(input logic [9:0] got, input logic [9:0] exp);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One host I/O cycle with checks while held and after release
    task automatic run_io(input logic [9:0] addr, input logic rd, input logic wide,
        input logic fwd);
        logic [9:0] ea;
        ea = wide ? addr : {2'b00, addr[7:0]};
        i_address_width_select = wide;
        i_host_addr = addr;
        i_host_data = addr[7:0] ^ 8'hC3;
        repeat (4) @(negedge i_core_clk);
        if (rd) i_host_ior_n = 1'b0;
        else i_host_iow_n = 1'b0;
        repeat (5) @(negedge i_core_clk);
        chk({6'h00, o_std_iorq_n, o_std_rd_n, o_std_wr_n, o_host_data_oe},
            {6'h00, !fwd, !(fwd && rd), !(fwd && !rd), fwd && rd});
        if (fwd) chk(o_std_addr, ea);
        chk({9'h000, o_host_chrdy}, 10'h001);
        if (fwd && rd) chk({2'b00, o_host_data}, {2'b00, ea[7:0] ^ 8'h5A});
        chk({1'b0, o_std_data_oe, o_std_data & {8{!rd}}},
            {1'b0, fwd && !rd, i_host_data & {8{!rd}}});
        i_host_ior_n = 1'b1;
        i_host_iow_n = 1'b1;
        repeat (5) @(negedge i_core_clk);
        chk({6'h00, o_std_iorq_n, o_std_rd_n, o_std_wr_n, o_host_data_oe}, 10'h00E);
    endtask
    // Hang guard
    always @(posedge i_core_clk) begin
        cycles++;
        if (cycles == 5000) begin
            errors++;
            finish_test();
        end
    end
    // Main sequence
    initial begin
        repeat (10) @(negedge i_core_clk);
        chk({9'h000, o_std_sysreset_n}, 10'h000);
        chk({5'h00, o_std_iorq_n, o_std_rd_n, o_std_wr_n, o_host_data_oe, o_host_chrdy},
            10'h01D);
        i_reset = 1'b0;
        @(negedge i_core_clk);
        chk({9'h000, o_std_sysreset_n}, 10'h001);
        foreach (rows[k]) run_io(rows[k].addr, rows[k].rd, rows[k].wide, rows[k].fwd);
        i_host_aen = 1'b1;
        run_io(10'h150, 1'b1, 1'b1, 1'b0);
        i_host_aen = 1'b0;
        i_host_memr_n = 1'b0;
        run_io(10'h150, 1'b0, 1'b0, 1'b0);
        i_host_memr_n = 1'b1;
        slow = 1'b1;
        i_host_ior_n = 1'b0;
        repeat (8) @(negedge i_core_clk);
        chk({9'h000, o_host_chrdy}, 10'h000);
        i_host_ior_n = 1'b1;
        slow = 1'b0;
        repeat (6) @(negedge i_core_clk);
        chk({9'h000, o_host_chrdy}, 10'h001);
        i_host_ior_n = 1'b0;
        i_host_iow_n = 1'b0;
        repeat (5) @(negedge i_core_clk);
        chk({6'h00, o_std_iorq_n, o_std_rd_n, o_std_wr_n, o_host_data_oe}, 10'h00E);
        i_host_ior_n = 1'b1;
        i_host_iow_n = 1'b1;
        for (int s = 0; s < 4; s++) begin
            i_irq_sel = {5{2'(s)}};
            i_std_req_n = ~(4'h1 << s);
            repeat (5) @(negedge i_core_clk);
            chk({5'h00, o_host_irq}, 10'h01F);
            i_std_req_n = {i_std_req_n[2:0], i_std_req_n[3]};
            repeat (5) @(negedge i_core_clk);
            chk({5'h00, o_host_irq}, 10'h000);
        end
        i_irq_sel = {2'h3, 2'h2, 2'h1, 2'h0, 2'h3};
        i_std_req_n = 4'b0110;
        repeat (5) @(negedge i_core_clk);
        chk({5'h00, o_host_irq}, 10'h013);
        i_reset = 1'b1;
        repeat (2) @(negedge i_core_clk);
        chk({4'h0, o_std_sysreset_n, o_host_irq}, 10'h000);
        i_reset = 1'b0;
        run_io(10'h1A5, 1'b0, 1'b0, 1'b1);
        finish_test();
    end
endmodule // host_std_bridge_bench

// ### sim/std_card_model.sv
// Behavioural STD Bus I/O card facing the bridge
module std_card_model (
    input wire logic i_core_clk,
    input wire logic [9:0] i_addr,
    input wire logic i_iorq_n,
    input wire logic i_rd_n,
    input wire logic i_slow,
    output logic [7:0] o_data,
    output logic o_wait_n
);
    timeunit 1ns;
    timeprecision 1ps;
    // Moving filler so a released bus does not keep showing the last byte
    logic [7:0] filler = 8'h00;
    // Filler flips every cycle
    always @(posedge i_core_clk) begin
        filler <= ~filler;
    end
    // Card byte only while read-selected
    assign o_data = (!i_iorq_n && !i_rd_n) ? (i_addr[7:0] ^ 8'h5A) : filler;
    // Slow card holds wait for as long as it is selected
    assign o_wait_n = !(i_slow && !i_iorq_n);
endmodule // std_card_model
